/* File: rtl/xpb_pkg.sv */
package xpb_pkg;

  // ***************************************************
  // Timing
  // ***************************************************
  // Overvoltage must persist this many horizontal lines before tripping
  localparam int unsigned XR_FILTER_LINES = 2;
  localparam logic [1:0] XR_FILTER_W_INIT = 2'h0;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic BLANK_HOLD_RST = 1'h1;
  localparam logic ALARM_RST = 1'h0;
  localparam logic DRIVE_RST = 1'h0;
  localparam logic VBLANK_RST = 1'h0;
  // Reset shows blanking with unlock, the safe level
  localparam logic [1:0] CODE_RST = 2'h1;

  // ***************************************************
  // Composite code bit positions
  // ***************************************************
  localparam int unsigned CODE_BLANK_BIT = 0;
  localparam int unsigned CODE_LOCK_BIT = 1;

  typedef enum logic [1:0] {
    XPB_IDLE,
    XPB_FILTER,
    XPB_TRIPPED
  } xpb_prot_e;

  // Analog comparator results, all synchronised before use
  typedef struct packed {
    logic sense_above;
    logic supply_prot_ok;
    logic supply_en_ok;
    logic supply_dis_ok;
  } xpb_supply_s;

  // Vertical timing pulses
  typedef struct packed {
    logic vsync;
    logic vdischarge;
  } xpb_vert_s;

endpackage

/* File: rtl/xpb_sync2.sv */
`timescale 1ns/1ps
// ***************************************************
// Two-flop synchroniser, one per bit
// ***************************************************
module xpb_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule

/* File: rtl/xpb_top.sv */
`timescale 1ns/1ps
// How it works
// - Overvoltage counts only while sense is high and supply above protection level.
// - After two lines of overvoltage, line and converter drives are switched off.
// - A trip sets the overvoltage alarm flag to one for the host.
// - Trip stays latched until supply drops or host pulses the clear bit.
// - Composite output carries lock state and early blanking simultaneously, four levels.
// - Early blanking starts at the first leading edge of sync or discharge.
// - Early blanking ends on discharge trailing edge, unless a sync leading edge comes in the same cycle.
// - Blank hold select at one holds blanking permanently, level chosen by lock.
// - Low supply, latched trip or frame drive disabled force permanent blanking.
module xpb_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic LINE_TICK,
  input wire xpb_pkg::xpb_supply_s SUPPLY_IN,
  input wire xpb_pkg::xpb_vert_s VERT_IN,
  input wire logic LINE_LOCK_LOOP_LOCKED,
  input wire logic BLANK_HOLD_SELECT,
  input wire logic FRAME_DRIVE_ENABLE,
  input wire logic OVERVOLTAGE_LATCH_CLEAR,
  input wire logic LINE_DRIVE_REQ,
  input wire logic CONVERTER_DRIVE_REQ,
  output logic LINE_DRIVE_OUT,
  output logic CONVERTER_DRIVE_OUT,
  output logic OVERVOLTAGE_ALARM_FLAG,
  output logic [1:0] LOCK_BLANK_COMPOSITE_OUT
);

  // ***************************************************
  // Input synchronisation
  // ***************************************************
  // Comparators and vertical pulses are asynchronous to the line clock
  // Lock passes the same two flops, so lock and blank bits stay aligned
  // Drive requests are already on this clock and skip the synchroniser
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn_in;
  xpb_pkg::xpb_supply_s sup;
  xpb_pkg::xpb_vert_s vert;
  logic locked;

  assign raw_in = {SUPPLY_IN, VERT_IN, LINE_LOCK_LOOP_LOCKED};

  xpb_sync2 #(.WIDTH(NSYNC)) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(raw_in),
    .q(syn_in)
  );

  assign sup = syn_in[6:3];
  assign vert = syn_in[2:1];
  assign locked = syn_in[0];

  // ***************************************************
  // Overvoltage protection
  // ***************************************************
  xpb_pkg::xpb_prot_e state_r, state_nxt;
  logic [1:0] lines_r, lines_nxt;
  logic alarm_r, alarm_nxt;
  logic ov_cond;
  logic supply_drop;

  // Supply drop releases the latch, so a trip does not outlive the supply
  // Qualified overvoltage
  assign ov_cond = sup.sense_above & sup.supply_prot_ok;
  assign supply_drop = ~sup.supply_dis_ok;

  always_comb begin
    state_nxt = state_r;
    lines_nxt = lines_r;
    alarm_nxt = alarm_r;
    case (state_r)
      xpb_pkg::XPB_IDLE: begin
        // Ticks count only in FILTER, so one cycle of entry precedes the first line
        lines_nxt = xpb_pkg::XR_FILTER_W_INIT;
        if (ov_cond) begin
          state_nxt = xpb_pkg::XPB_FILTER;
        end
      end
      xpb_pkg::XPB_FILTER: begin
        // Spike filter, a spike shorter than two lines resets the count
        if (!ov_cond) begin
          state_nxt = xpb_pkg::XPB_IDLE;
          lines_nxt = xpb_pkg::XR_FILTER_W_INIT;
        end else if (LINE_TICK) begin
          if (lines_r == 2'(xpb_pkg::XR_FILTER_LINES - 1)) begin
            state_nxt = xpb_pkg::XPB_TRIPPED;
            alarm_nxt = 1'h1;
          end else begin
            lines_nxt = lines_r + 2'h1;
          end
        end
      end
      xpb_pkg::XPB_TRIPPED: begin
        // A clear held high lets a lasting overvoltage trip again after two lines
        // Latched until supply drop or clear bit
        if (supply_drop || OVERVOLTAGE_LATCH_CLEAR) begin
          state_nxt = xpb_pkg::XPB_IDLE;
          alarm_nxt = 1'h0;
          lines_nxt = xpb_pkg::XR_FILTER_W_INIT;
        end
      end
      default: begin
        // Unused code falls back to IDLE, so a trip must qualify again
        state_nxt = xpb_pkg::XPB_IDLE;
        lines_nxt = xpb_pkg::XR_FILTER_W_INIT;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= xpb_pkg::XPB_IDLE;
      lines_r <= xpb_pkg::XR_FILTER_W_INIT;
      alarm_r <= xpb_pkg::ALARM_RST;
    end else begin
      state_r <= state_nxt;
      lines_r <= lines_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  // ***************************************************
  // Drive inhibit
  // ***************************************************
  logic line_drv_r, line_drv_nxt;
  logic conv_drv_r, conv_drv_nxt;
  logic inhibit;

  // Next state is used so the drives fall on the same edge as the alarm
  // Both drives off while tripped
  assign inhibit = (state_nxt == xpb_pkg::XPB_TRIPPED);

  always_comb begin
    line_drv_nxt = LINE_DRIVE_REQ & ~inhibit;
    conv_drv_nxt = CONVERTER_DRIVE_REQ & ~inhibit;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      line_drv_r <= xpb_pkg::DRIVE_RST;
      conv_drv_r <= xpb_pkg::DRIVE_RST;
    end else begin
      line_drv_r <= line_drv_nxt;
      conv_drv_r <= conv_drv_nxt;
    end
  end

  // ***************************************************
  // Early vertical blanking
  // ***************************************************
  logic vblank_r, vblank_nxt;
  logic vsync_d_r, vsync_d_nxt;
  logic vdis_d_r, vdis_d_nxt;
  logic lead_edge, dis_trail;

  // A sync edge after discharge has ended opens a blank that only the next discharge closes

  assign lead_edge = (vert.vsync & ~vsync_d_r) | (vert.vdischarge & ~vdis_d_r);
  assign dis_trail = ~vert.vdischarge & vdis_d_r;

  always_comb begin
    vblank_nxt = vblank_r;
    vsync_d_nxt = vert.vsync;
    vdis_d_nxt = vert.vdischarge;
    // End on discharge trailing edge only
    if (dis_trail) begin
      vblank_nxt = 1'h0;
    end
    if (lead_edge) begin
      vblank_nxt = 1'h1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // Edge registers reset to the idle low level, so no false edge follows reset
      vblank_r <= xpb_pkg::VBLANK_RST;
      vsync_d_r <= xpb_pkg::VBLANK_RST;
      vdis_d_r <= xpb_pkg::VBLANK_RST;
    end else begin
      vblank_r <= vblank_nxt;
      vsync_d_r <= vsync_d_nxt;
      vdis_d_r <= vdis_d_nxt;
    end
  end

  // ***************************************************
  // Composite lock / blank code
  // ***************************************************
  logic [1:0] code_r, code_nxt;
  logic blank_any;

  // Forced terms are ORed in last, so no mode can hide a fault
  // Hold mode and forced blanking
  assign blank_any = vblank_nxt | BLANK_HOLD_SELECT | ~sup.supply_en_ok | supply_drop
                     | inhibit | ~FRAME_DRIVE_ENABLE;

  always_comb begin
    code_nxt = 2'h0;
    // Two states carried together, as a two-bit code
    code_nxt[xpb_pkg::CODE_BLANK_BIT] = blank_any;
    code_nxt[xpb_pkg::CODE_LOCK_BIT] = locked;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      code_r <= xpb_pkg::CODE_RST;
    end else begin
      code_r <= code_nxt;
    end
  end

  // Every output is a register, so nothing combinational reaches a pin
  assign LINE_DRIVE_OUT = line_drv_r;
  assign CONVERTER_DRIVE_OUT = conv_drv_r;
  assign OVERVOLTAGE_ALARM_FLAG = alarm_r;
  assign LOCK_BLANK_COMPOSITE_OUT = code_r;

endmodule

/* File: sim/xpb_asserts.sv */
`timescale 1ns/1ps
// *****
// Checker
// *****
module xpb_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic LINE_TICK,
  input wire xpb_pkg::xpb_supply_s SUPPLY_IN,
  input wire xpb_pkg::xpb_vert_s VERT_IN,
  input wire logic LINE_LOCK_LOOP_LOCKED,
  input wire logic BLANK_HOLD_SELECT,
  input wire logic FRAME_DRIVE_ENABLE,
  input wire logic OVERVOLTAGE_LATCH_CLEAR,
  input wire logic LINE_DRIVE_REQ,
  input wire logic CONVERTER_DRIVE_REQ,
  input wire logic LINE_DRIVE_OUT,
  input wire logic CONVERTER_DRIVE_OUT,
  input wire logic OVERVOLTAGE_ALARM_FLAG,
  input wire logic [1:0] LOCK_BLANK_COMPOSITE_OUT
);
  wire a = OVERVOLTAGE_ALARM_FLAG;
  wire [1:0] c = LOCK_BLANK_COMPOSITE_OUT;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Async inputs reach the outputs three samples late
  chk_drive_gate: assert property (a |-> !LINE_DRIVE_OUT && !CONVERTER_DRIVE_OUT)
    else $error("drive on while tripped");
  chk_drive_follow: assert property (!a && $past(RST_N) |-> LINE_DRIVE_OUT == $past(LINE_DRIVE_REQ))
    else $error("drive not following request");
  chk_conv_follow: assert property (!a && $past(RST_N) |-> CONVERTER_DRIVE_OUT == $past(CONVERTER_DRIVE_REQ))
    else $error("converter not following request");
  chk_trip_cause: assert property ($rose(a) |-> $past(LINE_TICK) && $past(SUPPLY_IN[3:2], 3) == 2'h3)
    else $error("trip without cause");
  chk_latch_hold: assert property ($fell(a) |-> $past(OVERVOLTAGE_LATCH_CLEAR) || !$past(SUPPLY_IN[0], 3))
    else $error("latch dropped alone");
  chk_frame_blank: assert property (!FRAME_DRIVE_ENABLE [*2] |-> c[0])
    else $error("no forced blank");
  chk_hold_blank: assert property (BLANK_HOLD_SELECT [*2] |-> c[0])
    else $error("no held blank");
  chk_lock_bit: assert property ($past(RST_N, 3) |-> c[1] == $past(LINE_LOCK_LOOP_LOCKED, 3))
    else $error("lock bit wrong");
  chk_blank_end: assert property ($fell(c[0]) |-> !$past(VERT_IN[0], 3))
    else $error("blank ended early");
endmodule
bind xpb_top xpb_chk chk (.*);

/* File: sim/xpb_host.sv */
`timescale 1ns/1ps
// *****
// Host model, clears a trip promptly or slowly
// *****
module xpb_host (
  input wire logic clk,
  input wire logic alarm,
  input wire logic ack_en,
  input wire logic slow,
  output logic clr
);
  logic [2:0] wait_r = 3'h0;
  logic clr_r = 1'h0;
  assign clr = clr_r;
  always @(posedge clk) begin
    wait_r <= (alarm && ack_en) ? wait_r + 3'h1 : 3'h0;
    clr_r <= alarm && ack_en && wait_r == (slow ? 3'h5 : 3'h0);
  end
endmodule

/* File: sim/tb_xpb_top.sv */
`timescale 1ns/1ps
// *****
// Bench
// *****
module tb_xpb_top;
  logic REF_CLK = 1'h0, RST_N = 1'h0, LINE_TICK = 1'h0, LINE_LOCK_LOOP_LOCKED = 1'h0;
  logic BLANK_HOLD_SELECT = 1'h1, FRAME_DRIVE_ENABLE = 1'h1, LINE_DRIVE_REQ = 1'h0;
  logic CONVERTER_DRIVE_REQ = 1'h0, ack_en = 1'h0, slow = 1'h0, lk;
  logic OVERVOLTAGE_LATCH_CLEAR, LINE_DRIVE_OUT, CONVERTER_DRIVE_OUT, OVERVOLTAGE_ALARM_FLAG;
  logic [1:0] LOCK_BLANK_COMPOSITE_OUT;
  xpb_pkg::xpb_supply_s SUPPLY_IN = 4'h7;
  xpb_pkg::xpb_vert_s VERT_IN = 2'h0;
  int failures = 0, comparisons = 0, cy_n = 0, tn = 0;
  xpb_top uut (.*);
  xpb_host host (.clk(REF_CLK), .alarm(OVERVOLTAGE_ALARM_FLAG), .ack_en(ack_en), .slow(slow),
    .clr(OVERVOLTAGE_LATCH_CLEAR));
  always #2 REF_CLK = ~REF_CLK;
  // Ceiling is ten times the planned run
  always @(posedge REF_CLK) begin
    LINE_DRIVE_REQ <= 1'($urandom);
    CONVERTER_DRIVE_REQ <= 1'($urandom);
    cy_n <= cy_n + 1;
    if (cy_n == 3000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(logic [1:0] s, logic [1:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Inputs change by non-blocking assignment on the edge; checks see the values settled before it
  task automatic cy(int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task automatic ticks(int n);
    repeat (n) begin
      cy(3);
      LINE_TICK <= 1'h1;
      cy(1);
      LINE_TICK <= 1'h0;
    end
    cy(3);
  endtask
  task automatic tend();
    tn++;
    $display("test %0d done", tn);
  endtask
  function automatic logic [1:0] exp_c(logic l, logic b);
    return {l, b};
  endfunction
  task automatic stop_test();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(85987));
    cy(6);
    RST_N <= 1'h1;
    BLANK_HOLD_SELECT <= 1'h0;
    cy(6);
    chk(LOCK_BLANK_COMPOSITE_OUT, exp_c(1'h0, 1'h0));
    SUPPLY_IN <= 4'hF;
    cy(4);
    ticks(1);
    SUPPLY_IN <= 4'h7;
    cy(4);
    ticks(1);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h0);
    SUPPLY_IN <= 4'hB;
    cy(4);
    ticks(2);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h0);
    tend();
    SUPPLY_IN <= 4'hF;
    cy(4);
    ticks(2);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h1);
    chk({LINE_DRIVE_OUT, CONVERTER_DRIVE_OUT}, 2'h0);
    chk(LOCK_BLANK_COMPOSITE_OUT[0], 1'h1);
    SUPPLY_IN <= 4'h7;
    cy(10);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h1);
    slow <= 1'h1;
    ack_en <= 1'h1;
    cy(12);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h0);
    ack_en <= 1'h0;
    tend();
    SUPPLY_IN <= 4'hF;
    cy(4);
    ticks(2);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h1);
    SUPPLY_IN <= 4'h0;
    cy(5);
    chk(LOCK_BLANK_COMPOSITE_OUT[0], 1'h1);
    SUPPLY_IN <= 4'h7;
    cy(5);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h0);
    tend();
    SUPPLY_IN <= 4'hF;
    cy(4);
    ticks(2);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h1);
    slow <= 1'h0;
    ack_en <= 1'h1;
    SUPPLY_IN <= 4'h7;
    cy(4);
    chk(OVERVOLTAGE_ALARM_FLAG, 1'h0);
    ack_en <= 1'h0;
    SUPPLY_IN <= 4'h5;
    cy(4);
    chk(LOCK_BLANK_COMPOSITE_OUT[0], 1'h1);
    SUPPLY_IN <= 4'h7;
    cy(4);
    chk(LOCK_BLANK_COMPOSITE_OUT, exp_c(1'h0, 1'h0));
    tend();
    // Either vertical pulse may lead; sync always ends first
    repeat (8) begin
      lk = 1'($urandom);
      LINE_LOCK_LOOP_LOCKED <= lk;
      VERT_IN <= 2'($urandom_range(1, 3));
      cy(5);
      chk(LOCK_BLANK_COMPOSITE_OUT, exp_c(lk, 1'h1));
      VERT_IN <= 2'h1;
      cy(5);
      chk(LOCK_BLANK_COMPOSITE_OUT[0], 1'h1);
      VERT_IN <= 2'h0;
      cy(5);
      chk(LOCK_BLANK_COMPOSITE_OUT, exp_c(lk, 1'h0));
    end
    // Discharge ending while sync is still high must end the blank
    VERT_IN <= 2'h3;
    cy(5);
    VERT_IN <= 2'h2;
    cy(5);
    chk(LOCK_BLANK_COMPOSITE_OUT, exp_c(lk, 1'h0));
    VERT_IN <= 2'h0;
    cy(5);
    chk(LOCK_BLANK_COMPOSITE_OUT, exp_c(lk, 1'h0));
    tend();
    FRAME_DRIVE_ENABLE <= 1'h0;
    cy(4);
    chk(LOCK_BLANK_COMPOSITE_OUT[0], 1'h1);
    FRAME_DRIVE_ENABLE <= 1'h1;
    BLANK_HOLD_SELECT <= 1'h1;
    cy(4);
    chk(LOCK_BLANK_COMPOSITE_OUT, exp_c(lk, 1'h1));
    LINE_LOCK_LOOP_LOCKED <= ~lk;
    cy(5);
    chk(LOCK_BLANK_COMPOSITE_OUT, exp_c(~lk, 1'h1));
    tend();
    stop_test();
  end
endmodule
